//--- verilog/period_timer_consts.vh
`ifndef PERIOD_TIMER_CONSTS_VH
`define PERIOD_TIMER_CONSTS_VH
// Register byte offsets
`define OFS_COUNT 12'h000
`define OFS_PERIOD 12'h004
`define OFS_CONTROL 12'h008
`define OFS_CONTROL_ONE 12'h00C
`define OFS_HLIMIT 12'h010
`define OFS_STATUS 12'h014
// Reset values
`define COUNT_RST 8'h00
`define PERIOD_RST 8'hFF
`define CTL_RST 8'h00
`define CTL_ONE_RST 5'h00
// timer_control fields
`define CTL_ON 7
`define CTL_PRE_HI 6
`define CTL_PRE_LO 4
// timer_control_one fields
`define POST_HI 4
`define POST_LO 0
// hardware_limit_control mode field
`define MODE_HI 4
`define MODE_LO 0
// Mode encodings
`define MODE_FREE 5'h00
`define MODE_GATE_HI 5'h01
`define MODE_GATE_LO 5'h02
`define MODE_RST_EDGE_R 5'h03
`define MODE_RST_EDGE_F 5'h04
`define MODE_RST_EDGE_B 5'h05
`define MODE_RST_LVL_LO 5'h06
`define MODE_RST_LVL_HI 5'h07
`define MODE_ONESHOT 5'h08
`define MODE_OS_EDGE_R 5'h09
`define MODE_MONO_EDGE_R 5'h10
`define MODE_MONO_EDGE_B 5'h11
`endif

//--- verilog/prescaler.v
`include "period_timer_consts.vh"
module prescaler #(
  parameter W = 7
) (
  // Clock and reset
  input wire hclk,
  input wire hresetn,
  // Control
  input wire run,
  input wire clear,
  input wire [2:0] sel,
  // Tick out
  output wire tick
);
  reg [W-1:0] cnt_r;
  wire [W-1:0] lim = (({{(W-1){1'b0}}, 1'b1}) << sel) - {{(W-1){1'b0}}, 1'b1};
  assign tick = run && (cnt_r == lim);
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cnt_r <= {W{1'b0}};
    end else if (clear) begin
      cnt_r <= {W{1'b0}};
    end else if (run) begin
      cnt_r <= tick ? {W{1'b0}} : cnt_r + {{(W-1){1'b0}}, 1'b1};
    end
  end
endmodule // prescaler

//--- verilog/postscaler.v
`include "period_timer_consts.vh"
module postscaler (
  // Clock and reset
  input wire hclk,
  input wire hresetn,
  // Control
  input wire clear,
  input wire advance,
  input wire [4:0] ratio,
  // Pulse out
  output reg pulse_r
);
  reg [4:0] cnt_r;
  wire hit = advance && (cnt_r == ratio);
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cnt_r <= 5'h00;
      pulse_r <= 1'b0;
    end else begin
      pulse_r <= hit && !clear;
      if (clear || hit) begin
        cnt_r <= 5'h00;
      end else if (advance) begin
        cnt_r <= cnt_r + 5'h01;
      end
    end
  end
endmodule // postscaler

//--- verilog/period_timer.v
`include "period_timer_consts.vh"
module period_timer #(
  parameter PRE_W = 7
) (
  // AHB-Lite slave
  input wire hclk,
  input wire hresetn,
  input wire hsel,
  input wire [11:0] haddr,
  input wire [1:0] htrans,
  input wire hwrite,
  input wire [2:0] hsize,
  input wire [31:0] hwdata,
  input wire hready,
  output reg [31:0] hrdata,
  output wire hreadyout,
  output wire hresp,
  // External hardware reset/gate source
  input wire ext_reset_src,
  input wire debug_freeze,
  // Outputs to converter, waveform unit and PWM logic
  output wire postscaled_pulse,
  output wire adc_trigger,
  output wire shutdown_source,
  output reg [7:0] pwm_count,
  output reg pwm_period_match,
  output reg pwm_tick
);
  reg [7:0] timer_count_r;
  reg [7:0] period_value_r;
  reg [7:0] timer_control_r;
  reg [4:0] timer_control_one_r;
  reg [4:0] hardware_limit_control_r;
  reg halted_r;
  reg ext_prev_r;
  reg wr_pend_r;
  reg [11:0] wr_addr_r;
  reg [7:0] timer_count_nxt;
  reg halted_nxt;
  reg clear_on;
  reg run_en;
  reg ext_rst;

  wire [4:0] mode = hardware_limit_control_r;
  wire timer_on_bit = timer_control_r[`CTL_ON];
  wire ext_in = debug_freeze ? ext_prev_r : ext_reset_src;
  wire rise = ext_in && !ext_prev_r;
  wire fall = !ext_in && ext_prev_r;
  wire tick;
  wire match = timer_count_r == period_value_r;
  wire wr_count = wr_pend_r && (wr_addr_r == `OFS_COUNT);
  wire wr_ctl = wr_pend_r && (wr_addr_r == `OFS_CONTROL);
  wire wr_ctl_one = wr_pend_r && (wr_addr_r == `OFS_CONTROL_ONE);
  wire wr_hlt = wr_pend_r && (wr_addr_r == `OFS_HLIMIT);
  wire scaler_clear = wr_count || wr_ctl || ext_rst;
  // A count write wins over a period match, so no advance is reported
  wire adv = tick && match && !ext_rst && !wr_count;

  function is_oneshot;
    input [4:0] m;
    begin
      is_oneshot = (m == `MODE_ONESHOT) || (m == `MODE_OS_EDGE_R);
    end
  endfunction

  function is_mono;
    input [4:0] m;
    begin
      is_mono = (m == `MODE_MONO_EDGE_R) || (m == `MODE_MONO_EDGE_B);
    end
  endfunction

  // Gate, reset and stop control from the mode field
  always @* begin
    run_en = timer_on_bit && !halted_r;
    ext_rst = 1'b0;
    halted_nxt = halted_r;
    case (mode)
      `MODE_FREE: begin
        run_en = run_en;
      end
      `MODE_GATE_HI: begin
        run_en = run_en && ext_in;
      end
      `MODE_GATE_LO: begin
        run_en = run_en && !ext_in;
      end
      `MODE_RST_EDGE_R: begin
        ext_rst = rise;
      end
      `MODE_RST_EDGE_F: begin
        ext_rst = fall;
      end
      `MODE_RST_EDGE_B: begin
        ext_rst = rise || fall;
      end
      `MODE_RST_LVL_LO: begin
        ext_rst = !ext_in;
      end
      `MODE_RST_LVL_HI: begin
        ext_rst = ext_in;
      end
      `MODE_ONESHOT: begin
        run_en = run_en;
      end
      `MODE_OS_EDGE_R: begin
        ext_rst = rise;
      end
      `MODE_MONO_EDGE_R: begin
        ext_rst = rise;
      end
      `MODE_MONO_EDGE_B: begin
        ext_rst = rise || fall;
      end
      default: begin
        run_en = run_en;
      end
    endcase
    ext_rst = ext_rst && timer_on_bit;
    if (ext_rst && is_mono(mode)) begin
      halted_nxt = 1'b0;
    end else if (adv && (is_oneshot(mode) || is_mono(mode))) begin
      halted_nxt = 1'b1;
    end
    if (wr_ctl) begin
      halted_nxt = 1'b0;
    end
    clear_on = adv && is_oneshot(mode);
  end

  // Count next value
  always @* begin
    timer_count_nxt = timer_count_r;
    if (wr_count) begin
      timer_count_nxt = hwdata[7:0];
    end else if (ext_rst) begin
      timer_count_nxt = `COUNT_RST;
    end else if (tick) begin
      timer_count_nxt = match ? `COUNT_RST : timer_count_r + 8'h01;
    end
  end

  prescaler #(
    .W(PRE_W)
  ) u_pre (
    .hclk(hclk),
    .hresetn(hresetn),
    .run(run_en),
    .clear(scaler_clear),
    .sel(timer_control_r[`CTL_PRE_HI:`CTL_PRE_LO]),
    .tick(tick)
  );

  // One-shot with nonzero ratio simply never reaches its pulse
  postscaler u_post (
    .hclk(hclk),
    .hresetn(hresetn),
    .clear(scaler_clear),
    .advance(adv),
    .ratio(timer_control_one_r[`POST_HI:`POST_LO]),
    .pulse_r(postscaled_pulse)
  );

  assign adc_trigger = postscaled_pulse;
  assign shutdown_source = postscaled_pulse;
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;

  // Timer state
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      timer_count_r <= `COUNT_RST;
      halted_r <= 1'b0;
      ext_prev_r <= 1'b0;
      pwm_count <= `COUNT_RST;
      pwm_period_match <= 1'b0;
      pwm_tick <= 1'b0;
    end else begin
      timer_count_r <= timer_count_nxt;
      halted_r <= halted_nxt;
      ext_prev_r <= ext_in;
      pwm_count <= timer_count_nxt;
      pwm_period_match <= adv;
      pwm_tick <= tick;
    end
  end

  // Bus address phase capture and register writes
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend_r <= 1'b0;
      wr_addr_r <= 12'h000;
      period_value_r <= `PERIOD_RST;
      timer_control_r <= `CTL_RST;
      timer_control_one_r <= `CTL_ONE_RST;
      hardware_limit_control_r <= `MODE_FREE;
    end else begin
      if (hready) begin
        wr_pend_r <= hsel && htrans[1] && hwrite;
        wr_addr_r <= {haddr[11:2], 2'b00};
      end else begin
        wr_pend_r <= 1'b0;
      end
      if (wr_pend_r && (wr_addr_r == `OFS_PERIOD)) begin
        period_value_r <= hwdata[7:0];
      end
      if (wr_ctl) begin
        timer_control_r <= hwdata[7:0];
      end else if (clear_on) begin
        timer_control_r[`CTL_ON] <= 1'b0;
      end
      if (wr_ctl_one) begin
        timer_control_one_r <= hwdata[`POST_HI:`POST_LO];
      end
      if (wr_hlt) begin
        hardware_limit_control_r <= hwdata[`MODE_HI:`MODE_LO];
      end
    end
  end

  // Read data registered at the address phase
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata <= 32'h0000_0000;
    end else if (hready && hsel && htrans[1] && !hwrite) begin
      case ({haddr[11:2], 2'b00})
        `OFS_COUNT: hrdata <= {24'h00_0000, timer_count_r};
        `OFS_PERIOD: hrdata <= {24'h00_0000, period_value_r};
        `OFS_CONTROL: hrdata <= {24'h00_0000, timer_control_r};
        `OFS_CONTROL_ONE: hrdata <= {27'h000_0000, timer_control_one_r};
        `OFS_HLIMIT: hrdata <= {27'h000_0000, hardware_limit_control_r};
        `OFS_STATUS: hrdata <= {29'h0000_0000, ext_prev_r, halted_r, run_en};
        default: hrdata <= 32'h0000_0000;
      endcase
    end
  end
endmodule // period_timer

//--- bench/period_timer_assertions.sv
module period_timer_assertions (
  // Clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // Bus answer
  input wire logic hreadyout,
  input wire logic hresp,
  // Timer outputs
  input wire logic postscaled_pulse,
  input wire logic adc_trigger,
  input wire logic shutdown_source,
  input wire logic [7:0] pwm_count,
  input wire logic pwm_period_match,
  input wire logic pwm_tick
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge hclk);
  endclocking
  default disable iff (!hresetn);
  ready_okay_a: assert property (hreadyout && !hresp)
    else $error("bus answer not ready or not okay");
  adc_copy_a: assert property (adc_trigger == postscaled_pulse)
    else $error("converter trigger differs from pulse");
  shut_copy_a: assert property (shutdown_source == postscaled_pulse)
    else $error("shutdown source differs from pulse");
  pulse_match_a: assert property (postscaled_pulse |-> pwm_period_match)
    else $error("pulse without period match");
  pulse_single_a: assert property (postscaled_pulse |=> !postscaled_pulse)
    else $error("pulse wider than one clock");
  match_zero_a: assert property (pwm_period_match |-> pwm_count == 8'h00)
    else $error("count not zero after match");
  match_tick_a: assert property (pwm_period_match |-> pwm_tick)
    else $error("match without tick");
  reset_clear_a: assert property ($rose(hresetn) |-> pwm_count == 8'h00 && !postscaled_pulse)
    else $error("count or pulse not cleared by reset");
endmodule // period_timer_assertions

bind period_timer period_timer_assertions u_chk (.hclk, .hresetn, .hreadyout, .hresp,
  .postscaled_pulse, .adc_trigger, .shutdown_source, .pwm_count, .pwm_period_match, .pwm_tick);

//--- bench/ext_source_model.sv
module ext_source_model (
  // Clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // Requested level and line
  input wire logic want,
  output logic ext_reset_src
);
  timeunit 1ns;
  timeprecision 1ps;
  int gap;
  // Changes no sooner than seven clocks apart, so levels also last seven
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ext_reset_src <= 1'b0;
      gap <= 0;
    end else if (want != ext_reset_src && gap >= 6) begin
      ext_reset_src <= want;
      gap <= 0;
    end else if (gap < 6) begin
      gap <= gap + 1;
    end
  end
endmodule // ext_source_model

//--- bench/period_timer_tb_top.sv
`define CHK(a, e) begin compares++; if ((a) !== (e)) begin mismatches++; \
  $display("MISMATCH t=%0t got=%h exp=%h", $time, a, e); end end
module period_timer_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic hclk = 0;
  logic hresetn = 0;
  logic [11:0] haddr = 12'h000;
  logic [1:0] htrans = 2'b00;
  logic hwrite = 0;
  logic [31:0] hwdata = 32'h0000_0000;
  logic [31:0] hrdata, q;
  logic hreadyout, hresp, pulse, ext, seen;
  logic want = 0;
  logic freeze = 0;
  logic [7:0] cnt, c;
  int mismatches = 0;
  int compares = 0;
  int cyc = 0;
  always #12.5 hclk = ~hclk;
  ext_source_model u_src (.hclk(hclk), .hresetn(hresetn), .want(want), .ext_reset_src(ext));
  period_timer u_dut (.hclk(hclk), .hresetn(hresetn), .hsel(1'b1), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(3'b010), .hwdata(hwdata), .hready(hreadyout),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .ext_reset_src(ext),
    .debug_freeze(freeze), .postscaled_pulse(pulse), .adc_trigger(), .shutdown_source(),
    .pwm_count(cnt), .pwm_period_match(), .pwm_tick());
  task automatic bus(input logic w, input logic [11:0] a, input logic [7:0] d);
    haddr <= a;
    hwrite <= w;
    htrans <= 2'b10;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    htrans <= 2'b00;
    hwdata <= {24'h00_0000, d};
    do @(posedge hclk); while (hreadyout !== 1'b1);
    q = hrdata;
  endtask
  task regs_reset;
    bus(0, 12'h000, 8'h00);
    `CHK(q[7:0], 8'h00)
    bus(0, 12'h004, 8'h00);
    `CHK(q[7:0], 8'hFF)
    bus(0, 12'h020, 8'h00);
    `CHK(q, 32'h0000_0000)
    bus(1, 12'h000, 8'h05);
    bus(0, 12'h000, 8'h00);
    `CHK(q[7:0], 8'h05)
  endtask
  task free_run;
    int n;
    bus(1, 12'h004, 8'h03);
    bus(1, 12'h00C, 8'h01);
    bus(1, 12'h010, 8'h00);
    bus(1, 12'h008, 8'h80);
    while (pulse !== 1'b1) @(posedge hclk);
    n = 0;
    do begin
      @(posedge hclk);
      n++;
    end while (pulse !== 1'b1);
    `CHK(n, 8)
    bus(1, 12'h008, 8'h00);
    @(posedge hclk);
    c = cnt;
    repeat (6) @(posedge hclk);
    `CHK(cnt, c)
    `CHK(pulse, 1'b0)
    bus(1, 12'h008, 8'h00);
    bus(0, 12'h000, 8'h00);
    `CHK(q[7:0], c)
  endtask
  task one_shot;
    bus(1, 12'h000, 8'h00);
    bus(1, 12'h010, 8'h08);
    bus(1, 12'h004, 8'h02);
    bus(1, 12'h00C, 8'h00);
    bus(1, 12'h008, 8'h80);
    repeat (12) @(posedge hclk);
    bus(0, 12'h008, 8'h00);
    `CHK(q[7], 1'b0)
    `CHK(cnt, 8'h00)
  endtask
  task mono;
    bus(1, 12'h000, 8'h00);
    bus(1, 12'h010, 8'h10);
    bus(1, 12'h008, 8'h80);
    repeat (12) @(posedge hclk);
    bus(0, 12'h008, 8'h00);
    `CHK(q[7], 1'b1)
    want <= 1'b1;
    seen = 1'b0;
    repeat (20) begin
      @(posedge hclk);
      seen = seen | pulse;
    end
    `CHK(seen, 1'b1)
  endtask
  task gate;
    bus(1, 12'h004, 8'hFF);
    bus(1, 12'h000, 8'h00);
    want <= 1'b0;
    bus(1, 12'h010, 8'h01);
    repeat (8) @(posedge hclk);
    bus(1, 12'h008, 8'h80);
    c = cnt;
    repeat (5) @(posedge hclk);
    `CHK(cnt, c)
    want <= 1'b1;
    repeat (10) @(posedge hclk);
    `CHK(cnt == c, 1'b0)
  endtask
  task lvl;
    bus(1, 12'h010, 8'h07);
    repeat (3) @(posedge hclk);
    `CHK(cnt, 8'h00)
    want <= 1'b0;
    repeat (9) @(posedge hclk);
    freeze <= 1'b1;
    want <= 1'b1;
    repeat (10) @(posedge hclk);
    `CHK(cnt == 8'h00, 1'b0)
    freeze <= 1'b0;
  endtask
  task zero_seen;
    seen = 1'b0;
    repeat (12) begin
      @(posedge hclk);
      seen = seen | (cnt == 8'h00);
    end
  endtask
  task edge_reset;
    bus(1, 12'h010, 8'h03);
    want <= 1'b0;
    repeat (20) @(posedge hclk);
    `CHK(cnt == 8'h00, 1'b0)
    want <= 1'b1;
    zero_seen;
    `CHK(seen, 1'b1)
    bus(1, 12'h010, 8'h04);
    repeat (20) @(posedge hclk);
    want <= 1'b0;
    zero_seen;
    `CHK(seen, 1'b1)
    bus(1, 12'h010, 8'h05);
    repeat (20) @(posedge hclk);
    want <= 1'b1;
    zero_seen;
    `CHK(seen, 1'b1)
    bus(1, 12'h010, 8'h06);
    repeat (20) @(posedge hclk);
    want <= 1'b0;
    zero_seen;
    `CHK(seen, 1'b1)
    bus(1, 12'h010, 8'h02);
    repeat (10) @(posedge hclk);
    want <= 1'b1;
    repeat (4) @(posedge hclk);
    c = cnt;
    `CHK(c == 8'h00, 1'b0)
    repeat (5) @(posedge hclk);
    `CHK(cnt, c)
  endtask
  task tally_and_finish;
    $display("Compares %0d, mismatches %0d", compares, mismatches);
    if (mismatches == 0 && compares > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  always @(posedge hclk) begin
    cyc++;
    if (cyc == 5000) begin
      mismatches++;
      tally_and_finish;
    end
  end
  initial begin
    repeat (8) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    regs_reset;
    free_run;
    one_shot;
    mono;
    gate;
    lvl;
    edge_reset;
    tally_and_finish;
  end
endmodule // period_timer_tb_top
